// file: logic/udpf_pins.sv
/*
 * Mode-dependent pin functions of a FIFO UART: interrupt/ready pins, baud
 * clock out, receive clock select, address decode, drive disable, user and
 * RS-485 direction outputs, with an AXI4-Lite register slave.
 * Assumes UART core status inputs share i_clk_sys; pins are asynchronous.
 */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module udpf_pins import udpf_pkg::*; (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic [3:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [3:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	input  wire logic        i_mode_select,
	input  wire logic        i_port_choice_1,
	input  wire logic        i_port_choice_2,
	input  wire logic        i_port_choice_3,
	input  wire logic [6:0]  i_addr_hi,
	input  wire logic        i_addr_enable_n,
	input  wire logic        i_wide_bus_option_n,
	input  wire logic        i_rx_error,
	input  wire logic        i_rx_avail,
	input  wire logic        i_tx_space,
	input  wire logic        i_tx_hold_empty,
	input  wire logic        i_modem_change,
	input  wire logic        i_tx_busy,
	input  wire logic        i_baud16x_en,
	input  wire logic        i_host_read,
	input  wire logic        i_break_status_bit,
	output logic             o_pc_int_line_a,
	output logic             o_pc_int_line_a_oe_n,
	output logic             o_pc_int_line_b,
	output logic             o_pc_int_line_c,
	output logic             o_baud_clock_out_n,
	output logic             o_drive_disable_n,
	output logic             o_user_output_1_n,
	output logic             o_user_output_2_n,
	output logic             o_port_choice_3_oe_n,
	output logic             o_rx_clk_en,
	output logic             o_com_hit,
	output logic             o_serial_enable
);
	// ==========================================================
	// pin synchronisers
	logic [12:0] pin_s;
	logic        rclk_d_r;

	udpf_sync2 #(.W(13), .RST(UDPF_PIN_RST)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_async   ({i_mode_select, i_port_choice_3, i_port_choice_2, i_port_choice_1,
			i_addr_hi, i_addr_enable_n, i_wide_bus_option_n}),
		.o_sync    (pin_s)
	);

	wire       pc_mode   = ~pin_s[12];
	wire [2:0] choice    = {pin_s[11], pin_s[10], pin_s[9]};
	wire       rclk_s    = pin_s[10];
	wire [6:0] addr_s    = pin_s[8:2];
	wire       aen_s     = ~pin_s[1];
	wire       wide_bus  = ~pin_s[0];

	// ==========================================================
	// registers
	logic [7:0] mdm_ctl_r;
	logic [3:0] int_en_r;
	logic [7:0] feat_ctl_r;

	// ==========================================================
	// AXI4-Lite write channel
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [3:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        bvalid_r;

	wire aw_take   = i_s_axi_awvalid & o_s_axi_awready;
	wire w_take    = i_s_axi_wvalid & o_s_axi_wready;
	wire do_write  = aw_hold_r & w_hold_r;
	wire aw_nxt    = (aw_hold_r | aw_take) & ~do_write;
	wire w_nxt     = (w_hold_r | w_take) & ~do_write;
	wire bv_nxt    = do_write | (bvalid_r & ~i_s_axi_bready);
	wire wr_lane0  = do_write & wstrb_r[0];
	wire wr_mdm_ctl  = wr_lane0 & (awaddr_r == UDPF_OFS_MDM_CTL);
	wire wr_int_en   = wr_lane0 & (awaddr_r == UDPF_OFS_INT_EN);
	wire wr_feat_ctl = wr_lane0 & (awaddr_r == UDPF_OFS_FEAT_CTL);
	wire wr_mapped   = (awaddr_r == UDPF_OFS_MDM_CTL) | (awaddr_r == UDPF_OFS_INT_EN)
		| (awaddr_r == UDPF_OFS_FEAT_CTL);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			aw_hold_r       <= 1'b0;
			w_hold_r        <= 1'b0;
			awaddr_r        <= 4'h0;
			wdata_r         <= 32'h0000_0000;
			wstrb_r         <= 4'h0;
			bvalid_r        <= 1'b0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready  <= 1'b0;
			o_s_axi_bresp   <= UDPF_RESP_OKAY;
		end else begin
			aw_hold_r       <= aw_nxt;
			w_hold_r        <= w_nxt;
			bvalid_r        <= bv_nxt;
			o_s_axi_awready <= ~aw_nxt & ~do_write & ~bv_nxt;
			o_s_axi_wready  <= ~w_nxt & ~do_write & ~bv_nxt;
			if (aw_take) begin
				awaddr_r <= i_s_axi_awaddr;
			end
			if (w_take) begin
				wdata_r <= i_s_axi_wdata;
				wstrb_r <= i_s_axi_wstrb;
			end
			if (do_write) begin
				o_s_axi_bresp <= wr_mapped ? UDPF_RESP_OKAY : UDPF_RESP_SLVERR;
			end
		end
	end
	assign o_s_axi_bvalid = bvalid_r;

	// host access stays live during reset release; registers clear under reset
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			mdm_ctl_r  <= UDPF_MDM_CTL_RST;
			int_en_r   <= UDPF_INT_EN_RST;
			feat_ctl_r <= UDPF_FEAT_CTL_RST;
		end else begin
			if (wr_mdm_ctl) begin
				mdm_ctl_r <= wdata_r[7:0];
			end
			if (wr_int_en) begin
				int_en_r <= wdata_r[3:0];
			end
			if (wr_feat_ctl) begin
				feat_ctl_r <= wdata_r[7:0];
			end
		end
	end

	// ==========================================================
	// interrupt qualification
	logic [3:0] cond;
	assign cond[UDPF_INT_EN_RXAV]  = i_rx_avail;
	assign cond[UDPF_INT_EN_TXMT]  = i_tx_hold_empty;
	assign cond[UDPF_INT_EN_RXERR] = i_rx_error;
	assign cond[UDPF_INT_EN_MODEM] = i_modem_change;
	wire irq_any  = |(cond & int_en_r);
	wire irq_qual = irq_any & mdm_ctl_r[UDPF_MDM_CTL_OUT2];

	// ==========================================================
	// address decode, PC mode only; receive clock edge detect for standard mode
	wire com_hit_w  = pc_mode & aen_s & (addr_s == UDPF_COM_BASE[choice]);
	wire lpt1_hit   = pc_mode & aen_s & (addr_s == UDPF_LPT1_BASE);
	wire printer_decode_2_n_hit   = pc_mode & aen_s & (addr_s == UDPF_PRINTER_DECODE_2_N_BASE);
	wire rclk_rise  = rclk_s & ~rclk_d_r;

	// ==========================================================
	// AXI4-Lite read channel
	logic rvalid_r;
	wire ar_take = i_s_axi_arvalid & o_s_axi_arready;
	wire rv_nxt  = ar_take | (rvalid_r & ~i_s_axi_rready);
	wire [31:0] stat_w = {24'h000000, pc_mode, wide_bus, ~o_user_output_1_n, o_com_hit,
		i_tx_space, i_rx_avail, irq_qual, irq_any};
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (i_s_axi_araddr)
			UDPF_OFS_MDM_CTL:  rd_mux = {24'h000000, mdm_ctl_r};
			UDPF_OFS_INT_EN:   rd_mux = {28'h0000000, int_en_r};
			UDPF_OFS_FEAT_CTL: rd_mux = {24'h000000, feat_ctl_r};
			UDPF_OFS_STAT: rd_mux = stat_w;
			default:       rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rvalid_r        <= 1'b0;
			o_s_axi_arready <= 1'b0;
			o_s_axi_rdata   <= 32'h0000_0000;
			o_s_axi_rresp   <= UDPF_RESP_OKAY;
		end else begin
			rvalid_r        <= rv_nxt;
			o_s_axi_arready <= ~rv_nxt;
			if (ar_take) begin
				o_s_axi_rdata <= rd_mux;
				o_s_axi_rresp <= rd_ok ? UDPF_RESP_OKAY : UDPF_RESP_SLVERR;
			end
		end
	end
	assign o_s_axi_rvalid = rvalid_r;

	// ==========================================================
	// pin output selection
	wire a_nxt    = pc_mode ? irq_qual : irq_any;
	wire a_oe_nxt = pc_mode ? ~mdm_ctl_r[UDPF_MDM_CTL_OUT2] : 1'b0;
	wire b_nxt    = pc_mode ? irq_qual : ~i_rx_avail;
	wire c_nxt    = pc_mode ? irq_qual : ~i_tx_space;
	wire baud_nxt = pc_mode ? ~lpt1_hit : ~i_baud16x_en;
	// external receive clock is sampled, so it must stay well below 25 MHz
	wire rxen_nxt = pc_mode ? i_baud16x_en : rclk_rise;
	wire drvdis_nxt = pc_mode ? ~printer_decode_2_n_hit
		: (wide_bus ? i_break_status_bit : ~i_host_read);
	wire uout1_nxt  = feat_ctl_r[UDPF_FEAT_CTL_DIR] ? ~i_tx_busy
		: ~mdm_ctl_r[UDPF_MDM_CTL_OUT1];

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rclk_d_r             <= 1'b1;
			o_pc_int_line_a      <= 1'b0;
			o_pc_int_line_a_oe_n <= 1'b1;
			o_pc_int_line_b      <= 1'b1;
			o_pc_int_line_c      <= 1'b1;
			o_baud_clock_out_n   <= 1'b1;
			o_drive_disable_n    <= 1'b1;
			o_user_output_1_n    <= 1'b1;
			o_user_output_2_n    <= 1'b1;
			o_port_choice_3_oe_n <= 1'b1;
			o_rx_clk_en          <= 1'b0;
			o_com_hit            <= 1'b0;
			o_serial_enable      <= 1'b0;
		end else begin
			rclk_d_r             <= rclk_s;
			o_pc_int_line_a      <= a_nxt;
			o_pc_int_line_a_oe_n <= a_oe_nxt;
			o_pc_int_line_b      <= b_nxt;
			o_pc_int_line_c      <= c_nxt;
			o_baud_clock_out_n   <= baud_nxt;
			o_drive_disable_n    <= drvdis_nxt;
			o_user_output_1_n    <= uout1_nxt;
			o_user_output_2_n    <= ~mdm_ctl_r[UDPF_MDM_CTL_OUT2];
			o_port_choice_3_oe_n <= pc_mode;
			o_rx_clk_en          <= rxen_nxt;
			o_com_hit            <= com_hit_w;
			o_serial_enable      <= 1'b1;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	property p_int_a_pc;
		pc_mode && !irq_qual |=> !o_pc_int_line_a;
	endproperty
	a_int_a_pc: assert property (p_int_a_pc) else $error("line A high without qualification");

	property p_int_gen_driven;
		!pc_mode |=> !o_pc_int_line_a_oe_n && (o_pc_int_line_a == $past(irq_any));
	endproperty
	a_int_gen_driven: assert property (p_int_gen_driven) else $error("interrupt pin not driven");

	property p_line_b_pc;
		pc_mode && irq_qual |=> o_pc_int_line_b;
	endproperty
	a_line_b_pc: assert property (p_line_b_pc) else $error("line B missed interrupt");

	property p_rx_ready;
		!pc_mode && i_rx_avail |=> !o_pc_int_line_b;
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("receive ready not low");

	property p_tx_ready;
		!pc_mode |=> o_pc_int_line_c == !$past(i_tx_space);
	endproperty
	a_tx_ready: assert property (p_tx_ready) else $error("transmit ready wrong");

	property p_baud_gen;
		!pc_mode && i_baud16x_en |=> !o_baud_clock_out_n;
	endproperty
	a_baud_gen: assert property (p_baud_gen) else $error("baud clock pulse missing");

	property p_rxclk_pc;
		pc_mode && i_baud16x_en |=> o_rx_clk_en;
	endproperty
	a_rxclk_pc: assert property (p_rxclk_pc) else $error("receiver clock not internal");

	property p_drvdis;
		!pc_mode && !wide_bus && i_host_read |=> !o_drive_disable_n;
	endproperty
	a_drvdis: assert property (p_drvdis) else $error("drive disable not low on read");

	property p_dir;
		feat_ctl_r[UDPF_FEAT_CTL_DIR] && i_tx_busy |=> !o_user_output_1_n;
	endproperty
	a_dir: assert property (p_dir) else $error("direction pin high during transmit");

	property p_uout1_ctl;
		wr_mdm_ctl ##1 !feat_ctl_r[UDPF_FEAT_CTL_DIR]
			|=> o_user_output_1_n == !$past(wdata_r[UDPF_MDM_CTL_OUT1], 2);
	endproperty
	a_uout1_ctl: assert property (p_uout1_ctl) else $error("output-1 pin ignores control bit");

	property p_line_c_pc;
		pc_mode && irq_qual |=> o_pc_int_line_c;
	endproperty
	a_line_c_pc: assert property (p_line_c_pc) else $error("line C missed interrupt");

	property p_uout2_gen;
		!pc_mode |=> !o_port_choice_3_oe_n
			&& (o_user_output_2_n == !$past(mdm_ctl_r[UDPF_MDM_CTL_OUT2]));
	endproperty
	a_uout2_gen: assert property (p_uout2_gen) else $error("output-2 pin wrong");

	property p_dir_idle;
		feat_ctl_r[UDPF_FEAT_CTL_DIR] && !i_tx_busy |=> o_user_output_1_n;
	endproperty
	a_dir_idle: assert property (p_dir_idle) else $error("direction pin low while idle");
endmodule : udpf_pins
`default_nettype wire

// file: logic/udpf_pkg.sv
/*
 * Constants shared by the dual-mode pin function block: register offsets,
 * field positions, reset values and address decode tables.
 * Assumes a 32-bit AXI4-Lite register bus and a 10-bit I/O address on pins.
 */
`default_nettype none
package udpf_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [3:0]  UDPF_OFS_MDM_CTL  = 4'h0;
	localparam logic [3:0]  UDPF_OFS_INT_EN   = 4'h4;
	localparam logic [3:0]  UDPF_OFS_FEAT_CTL = 4'h8;
	localparam logic [3:0]  UDPF_OFS_STAT     = 4'hC;
	// ==========================================================
	// field positions
	localparam int          UDPF_MDM_CTL_OUT1 = 2;
	localparam int          UDPF_MDM_CTL_OUT2 = 3;
	localparam int          UDPF_FEAT_CTL_DIR = 3;
	localparam int          UDPF_INT_EN_RXAV  = 0;
	localparam int          UDPF_INT_EN_TXMT  = 1;
	localparam int          UDPF_INT_EN_RXERR = 2;
	localparam int          UDPF_INT_EN_MODEM = 3;
	// ==========================================================
	// reset values
	localparam logic [7:0]  UDPF_MDM_CTL_RST  = 8'h00;
	localparam logic [3:0]  UDPF_INT_EN_RST   = 4'h0;
	localparam logic [7:0]  UDPF_FEAT_CTL_RST = 8'h00;
	localparam logic [12:0] UDPF_PIN_RST      = 13'h1FFF;
	// ==========================================================
	// bus answers
	localparam logic [1:0]  UDPF_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  UDPF_RESP_SLVERR  = 2'h2;
	// ==========================================================
	// address decode, compared against address lines 9..3
	localparam logic [6:0]  UDPF_COM_BASE [8] = '{7'h7F, 7'h5F, 7'h7D, 7'h5D,
		7'h7C, 7'h5C, 7'h7E, 7'h5E};
	localparam logic [6:0]  UDPF_LPT1_BASE    = 7'h6F;
	localparam logic [6:0]  UDPF_PRINTER_DECODE_2_N_BASE    = 7'h4F;
endpackage : udpf_pkg
`default_nettype wire

// file: logic/udpf_sync2.sv
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to i_clk_sys; one lane per bit.
 */
`timescale 1ns/1ns
`default_nettype none
module udpf_sync2 #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	// ==========================================================
	// per-bit double flop; first stage feeds only the second
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_lane
			logic meta_r;
			always_ff @(posedge i_clk_sys or posedge i_rst) begin
				if (i_rst) begin
					meta_r    <= RST[g];
					o_sync[g] <= RST[g];
				end else begin
					meta_r    <= i_async[g];
					o_sync[g] <= meta_r;
				end
			end
		end
	endgenerate
endmodule : udpf_sync2
`default_nettype wire

// file: tb/udpf_host_model.sv
/*
 * Host CPU model: an AXI4-Lite master with one write task and one read task.
 * Assumes the caller does not request before the second edge after reset release.
 */
`timescale 1ns/1ns
`default_nettype none
module udpf_host_model (
	input  wire logic        i_clk_sys,
	output logic [3:0]       i_s_axi_awaddr,
	output logic             i_s_axi_awvalid,
	input  wire logic        o_s_axi_awready,
	output logic [31:0]      i_s_axi_wdata,
	output logic [3:0]       i_s_axi_wstrb,
	output logic             i_s_axi_wvalid,
	input  wire logic        o_s_axi_wready,
	input  wire logic [1:0]  o_s_axi_bresp,
	input  wire logic        o_s_axi_bvalid,
	output logic             i_s_axi_bready,
	output logic [3:0]       i_s_axi_araddr,
	output logic             i_s_axi_arvalid,
	input  wire logic        o_s_axi_arready,
	input  wire logic [31:0] o_s_axi_rdata,
	input  wire logic [1:0]  o_s_axi_rresp,
	input  wire logic        o_s_axi_rvalid,
	output logic             i_s_axi_rready
);
	// ==========================================================
	// idle bus
	initial begin
		{i_s_axi_awaddr, i_s_axi_awvalid, i_s_axi_wdata, i_s_axi_wstrb, i_s_axi_wvalid} = '0;
		{i_s_axi_bready, i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} = '0;
	end
	// ==========================================================
	// transfers; each starts one edge late so no signal is assigned twice per step
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge i_clk_sys);
		i_s_axi_awaddr  <= a;
		i_s_axi_wdata   <= {24'h000000, d};
		i_s_axi_wstrb   <= 4'hF;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid  <= 1'b1;
		i_s_axi_bready  <= 1'b1;
		do begin
			@(posedge i_clk_sys);
			if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
			if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
		end while (!o_s_axi_bvalid);
		r = o_s_axi_bresp;
		i_s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_clk_sys);
		i_s_axi_araddr  <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready  <= 1'b1;
		do begin
			@(posedge i_clk_sys);
			if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
		end while (!o_s_axi_rvalid);
		d = o_s_axi_rdata;
		r = o_s_axi_rresp;
		i_s_axi_rready <= 1'b0;
	endtask : rd
endmodule : udpf_host_model
`default_nettype wire

// file: tb/uart_dual_mode_pin_functions_bench.sv
/*
 * Self-checking bench for the dual-mode pin block, register access via the host model.
 * Assumes core status inputs are driven on the system clock; pins settle in six edges.
 */
`timescale 1ns/1ns
`default_nettype none
module uart_dual_mode_pin_functions_bench;
	import udpf_pkg::*;
	logic i_clk_sys = 1'b0, i_rst = 1'b1;
	logic [3:0] i_s_axi_awaddr, i_s_axi_wstrb, i_s_axi_araddr;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rdat;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
	logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic i_mode_select = 1'b1, i_port_choice_1 = 1'b1, pc2_drv = 1'b1, i_port_choice_3 = 1'b1;
	logic [6:0] i_addr_hi = 7'h00;
	logic i_addr_enable_n = 1'b1, i_wide_bus_option_n = 1'b1, lp = 1'b0;
	logic i_rx_error = 1'b0, i_rx_avail = 1'b0, i_tx_space = 1'b0, i_tx_hold_empty = 1'b0;
	logic i_modem_change = 1'b0, i_tx_busy = 1'b0, i_baud16x_en = 1'b0;
	logic i_host_read = 1'b0, i_break_status_bit = 1'b0;
	logic o_pc_int_line_a, o_pc_int_line_a_oe_n, o_pc_int_line_b, o_pc_int_line_c;
	logic o_baud_clock_out_n, o_drive_disable_n, o_user_output_1_n, o_user_output_2_n;
	logic o_port_choice_3_oe_n, o_rx_clk_en, o_com_hit, o_serial_enable;
	wire logic i_port_choice_2 = lp ? o_baud_clock_out_n : pc2_drv;
	int n_mismatch = 0, check_count = 0, n_baud = 0, n_rxclk = 0;
	// ==========================================================
	// clock, units
	always #10 i_clk_sys = ~i_clk_sys;
	udpf_host_model u_udpf_host_model (.i_clk_sys, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
		.i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
		.o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready);
	udpf_pins u_udpf_pins (.i_clk_sys, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
		.i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
		.i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
		.o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_mode_select, .i_port_choice_1,
		.i_port_choice_2, .i_port_choice_3, .i_addr_hi, .i_addr_enable_n, .i_wide_bus_option_n,
		.i_rx_error, .i_rx_avail, .i_tx_space, .i_tx_hold_empty, .i_modem_change, .i_tx_busy,
		.i_baud16x_en, .i_host_read, .i_break_status_bit, .o_pc_int_line_a, .o_pc_int_line_a_oe_n,
		.o_pc_int_line_b, .o_pc_int_line_c, .o_baud_clock_out_n, .o_drive_disable_n,
		.o_user_output_1_n, .o_user_output_2_n, .o_port_choice_3_oe_n, .o_rx_clk_en, .o_com_hit,
		.o_serial_enable);
	always @(posedge i_clk_sys) begin
		if (o_baud_clock_out_n === 1'b0) n_baud++;
		if (o_rx_clk_en === 1'b1) n_rxclk++;
	end
	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic settle();
		repeat (6) @(posedge i_clk_sys);
	endtask : settle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_udpf_host_model.wr(a, d, resp);
	endtask : wr
	// pulses spaced out so the receive clock path sees each one
	task automatic pulses(input int n);
		n_baud = 0;
		n_rxclk = 0;
		repeat (n) begin
			i_baud16x_en <= 1'b1;
			@(posedge i_clk_sys);
			i_baud16x_en <= 1'b0;
			repeat (4) @(posedge i_clk_sys);
		end
		settle();
	endtask : pulses
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		n_mismatch++;
		tally_and_finish();
	end
	// ==========================================================
	// tests
	initial begin
		repeat (16) @(posedge i_clk_sys);
		chk({o_pc_int_line_a, o_pc_int_line_a_oe_n, o_pc_int_line_b, o_pc_int_line_c, o_baud_clock_out_n,
			o_drive_disable_n, o_user_output_1_n, o_user_output_2_n, o_port_choice_3_oe_n, o_rx_clk_en,
			o_com_hit, o_serial_enable}, 12'h7F8);
		i_rst <= 1'b0;
		settle();
		chk(o_serial_enable, 1);
		for (int i = 0; i < 3; i++) begin
			u_udpf_host_model.rd(4'(i * 4), rdat, resp);
			chk(rdat, 0);
			chk(resp, UDPF_RESP_OKAY);
		end
		u_udpf_host_model.rd(4'h2, rdat, resp);
		chk(rdat, 32'h00000000);
		chk(resp, UDPF_RESP_SLVERR);
		wr(4'h6, 8'hFF);
		chk(resp, UDPF_RESP_SLVERR);
		// standard mode pins
		wr(UDPF_OFS_MDM_CTL, 8'h0C);
		wr(UDPF_OFS_INT_EN, 8'h01);
		i_rx_avail <= 1'b1;
		i_tx_space <= 1'b1;
		settle();
		chk({o_user_output_1_n, o_user_output_2_n, o_port_choice_3_oe_n}, 0);
		chk({o_pc_int_line_a, o_pc_int_line_a_oe_n, o_pc_int_line_b, o_pc_int_line_c}, 4'h8);
		wr(UDPF_OFS_MDM_CTL, 8'h00);
		i_tx_space <= 1'b0;
		settle();
		chk({o_pc_int_line_a, o_pc_int_line_a_oe_n, o_pc_int_line_c, o_user_output_1_n}, 4'hB);
		i_rx_avail <= 1'b0;
		i_host_read <= 1'b1;
		settle();
		chk({o_pc_int_line_b, o_drive_disable_n}, 2'h2);
		i_wide_bus_option_n <= 1'b0;
		i_break_status_bit <= 1'b1;
		settle();
		chk(o_drive_disable_n, 1);
		{i_wide_bus_option_n, i_host_read} <= 2'h2;
		// half duplex direction, low only while sending; output-1 bit set so idle high proves the override
		wr(UDPF_OFS_MDM_CTL, 8'h04);
		wr(UDPF_OFS_FEAT_CTL, 8'h08);
		i_tx_busy <= 1'b1;
		settle();
		chk(o_user_output_1_n, 0);
		i_tx_busy <= 1'b0;
		settle();
		chk(o_user_output_1_n, 1);
		wr(UDPF_OFS_FEAT_CTL, 8'h00);
		lp <= 1'b1;
		pulses(5);
		chk(n_baud, 5);
		chk(n_rxclk, 5);
		chk(o_user_output_1_n, 0);
		lp <= 1'b0;
		{i_addr_enable_n, i_addr_hi} <= {1'b0, UDPF_COM_BASE[7]};
		settle();
		chk(o_com_hit, 0);
		// PC mode
		i_mode_select <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			{i_port_choice_3, pc2_drv, i_port_choice_1} <= 3'(k);
			i_addr_hi <= UDPF_COM_BASE[k];
			settle();
			chk(o_com_hit, 1);
			i_addr_hi <= UDPF_COM_BASE[k] ^ 7'h01;
			settle();
			chk(o_com_hit, 0);
		end
		i_addr_hi <= UDPF_LPT1_BASE;
		settle();
		chk({o_baud_clock_out_n, o_drive_disable_n}, 2'h1);
		i_addr_hi <= UDPF_PRINTER_DECODE_2_N_BASE;
		settle();
		chk({o_baud_clock_out_n, o_drive_disable_n}, 2'h2);
		i_addr_hi <= 7'h00;
		pulses(3);
		chk(n_rxclk, 3);
		chk(n_baud, 0);
		chk(o_port_choice_3_oe_n, 1);
		wr(UDPF_OFS_INT_EN, 8'h0F);
		wr(UDPF_OFS_MDM_CTL, 8'h08);
		for (int s = 0; s < 4; s++) begin
			{i_modem_change, i_rx_error, i_tx_hold_empty, i_rx_avail} <= 4'(1 << s);
			settle();
			chk({o_pc_int_line_a, o_pc_int_line_a_oe_n, o_pc_int_line_b, o_pc_int_line_c}, 4'hB);
		end
		wr(UDPF_OFS_INT_EN, 8'h00);
		settle();
		chk({o_pc_int_line_a, o_pc_int_line_a_oe_n, o_pc_int_line_b, o_pc_int_line_c}, 4'h0);
		wr(UDPF_OFS_INT_EN, 8'h0F);
		wr(UDPF_OFS_MDM_CTL, 8'h00);
		settle();
		chk({o_pc_int_line_a_oe_n, o_pc_int_line_b, o_pc_int_line_c}, 3'h4);
		tally_and_finish();
	end
endmodule : uart_dual_mode_pin_functions_bench
`default_nettype wire
